// *** common/touch_pkg.sv ***
package touch_pkg;
  localparam int WORD_BITS = 8;
  localparam logic [3:0] LAST_BIT_CNT = 4'h7;
  localparam int CHAN_HI_POS = 6;
  localparam int CHAN_MID_POS = 5;
  localparam int CHAN_LO_POS = 4;
  localparam int RES_POS = 3;
  localparam int REF_POS = 2;
  localparam int PWR_UPPER_POS = 1;
  localparam int PWR_LOWER_POS = 0;
  localparam logic PWR_UPPER_RST = 1'b1;
  localparam logic PWR_LOWER_RST = 1'b0;
  localparam logic REF_MODE_RST = 1'b1;
  localparam logic [2:0] RELEASE_FALL_CNT = 3'h3;
  localparam logic [3:0] CONV_FALLS_12 = 4'hc;
  localparam logic [3:0] CONV_FALLS_8 = 4'h8;
endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      pin_sync_out <= '0;
    end else begin
      meta <= pin_in;
      pin_sync_out <= meta;
    end
  end
endmodule

// *** src/touch_adc_pen_irq_control.sv ***
// Behaviour
// R1: When enabled, a screen touch pulls the pen interrupt low.
// R2: Pen interrupt stays responsive while the converter is powered down.
// R3: First conversion after power-up starts at once and is valid.
// R4: Pen interrupt is enabled straight after power-up.
// R5: A detected start flag disables the pen interrupt.
// R6: A low interrupt at start stays low until the fourth falling shift edge.
// R7: Releasing after the start flag does not re-arm; power bits decide.
// R8: The interrupt output idles released whether enabled or not.
// R9: Re-arming by the power bits takes effect only after conversion completes.
// R10: A start flag arriving before conversion end keeps the interrupt disabled.
// R11: Command bits are ignored until a start flag of one is seen.
// R12: Three channel bits select multiplexer, screen drivers and reference inputs.
// R13: Resolution bit zero selects 12-bit, one selects 8-bit conversion.
// R14: Reference bit one is single-ended, zero is differential.
// R15: Single-ended mode references the converter to the reference pin.
// R16: Host uses differential mode only for X, Y and pressure.
// R17: A new start flag is accepted once the previous word is in.
// R18: Word bits seven to zero: start, channel, resolution, reference, power.
// R19: Power bits both one disable the interrupt; other settings enable it.
// R20: Power-up defaults: lower power bit zero, upper power bit one.
// R21: Command bits shift in MSB first on rising shift clock edges.
// R22: The interrupt pin is driven low only, never actively high.
`timescale 1ns/1ns
module touch_adc_pen_irq_control (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial command pins
  input wire logic serial_shift_clock,
  input wire logic serial_cmd_in,
  // Touch sense from the screen
  input wire logic touch_detect,
  // Pen interrupt open-drain pin
  output logic pen_touch_irq_n_out,
  output logic pen_touch_irq_n_oe,
  // Decoded control word
  output logic chan_sel_hi,
  output logic chan_sel_mid,
  output logic chan_sel_lo,
  output logic res_8bit,
  output logic ref_mode_select,
  output logic ref_from_pin,
  output logic power_bit_upper,
  output logic power_bit_lower,
  // Conversion sequencing
  output logic conv_start,
  output logic conv_busy
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and shift clock edges
  logic [2:0] pins_sync;
  logic sclk_s, cmd_s, touch_s, sclk_d;

  pin_sync #(.WIDTH(3)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in({touch_detect, serial_cmd_in, serial_shift_clock}),
    .pin_sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign cmd_s = pins_sync[1];
  assign touch_s = pins_sync[2];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;

  function automatic logic [3:0] conv_limit(input logic eight_bit);
    conv_limit = eight_bit ? touch_pkg::CONV_FALLS_8 : touch_pkg::CONV_FALLS_12;
  endfunction

  function automatic logic pwr_enables_irq(input logic upper, input logic lower);
    pwr_enables_irq = ~(upper & lower);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control word shifter
  logic [3:0] bit_cnt;
  logic [5:0] shift;
  wire start_det = sclk_rise & (bit_cnt == 4'h0) & cmd_s; // [R11] [R21]
  wire word_done = sclk_rise & (bit_cnt == touch_pkg::LAST_BIT_CNT);
  wire [7:0] next_word = {1'b1, shift, cmd_s}; // [R18]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 4'h0;
      shift <= 6'h00;
    end else if (start_det) begin
      bit_cnt <= 4'h1;
    end else if (sclk_rise && bit_cnt != 4'h0) begin
      shift <= {shift[4:0], cmd_s}; // [R21]
      bit_cnt <= word_done ? 4'h0 : bit_cnt + 4'h1; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan_sel_hi <= 1'b0;
      chan_sel_mid <= 1'b0;
      chan_sel_lo <= 1'b0;
      res_8bit <= 1'b0;
      ref_mode_select <= touch_pkg::REF_MODE_RST;
      power_bit_upper <= touch_pkg::PWR_UPPER_RST; // [R20]
      power_bit_lower <= touch_pkg::PWR_LOWER_RST; // [R20]
    end else if (word_done) begin
      chan_sel_hi <= next_word[touch_pkg::CHAN_HI_POS]; // [R12]
      chan_sel_mid <= next_word[touch_pkg::CHAN_MID_POS]; // [R12]
      chan_sel_lo <= next_word[touch_pkg::CHAN_LO_POS]; // [R12]
      res_8bit <= next_word[touch_pkg::RES_POS]; // [R13]
      ref_mode_select <= next_word[touch_pkg::REF_POS]; // [R14]
      power_bit_upper <= next_word[touch_pkg::PWR_UPPER_POS];
      power_bit_lower <= next_word[touch_pkg::PWR_LOWER_POS];
    end
  end

  assign ref_from_pin = ref_mode_select; // [R15]

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timing in falling shift edges
  logic [3:0] conv_cnt;
  wire conv_done = sclk_fall & conv_busy & (conv_cnt + 4'h1 == conv_limit(res_8bit));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_busy <= 1'b0;
      conv_cnt <= 4'h0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= word_done; // [R3]
      if (word_done) begin
        conv_busy <= 1'b1;
        conv_cnt <= 4'h0;
      end else if (conv_done) begin
        conv_busy <= 1'b0;
      end else if (sclk_fall && conv_busy) begin
        conv_cnt <= conv_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pen interrupt enable and output
  logic pen_en, arm_pending, hold, irq_oe;
  logic [2:0] fall_cnt;
  wire release_now = sclk_fall & hold & (fall_cnt == touch_pkg::RELEASE_FALL_CNT);
  wire next_oe = (pen_en & ~start_det & touch_s) | (hold & ~release_now)
                 | (start_det & irq_oe);
  wire pwr_arm = pwr_enables_irq(next_word[touch_pkg::PWR_UPPER_POS],
    next_word[touch_pkg::PWR_LOWER_POS]);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pen_en <= 1'b1; // [R4]
      arm_pending <= 1'b0;
    end else begin
      if (start_det) begin
        pen_en <= 1'b0; // [R5]
        arm_pending <= 1'b0; // [R10]
      end else if (word_done) begin
        arm_pending <= pwr_arm; // [R19] [R7]
      end else if (conv_done) begin
        pen_en <= arm_pending; // [R9] [R2]
        arm_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold <= 1'b0;
      fall_cnt <= 3'h0;
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= next_oe; // [R1] [R8]
      if (start_det && irq_oe) begin
        hold <= 1'b1; // [R6]
        fall_cnt <= 3'h0;
      end else if (release_now) begin
        hold <= 1'b0; // [R6]
      end else if (sclk_fall && hold) begin
        fall_cnt <= fall_cnt + 3'h1;
      end
    end
  end

  assign pen_touch_irq_n_out = 1'b0; // [R22]
  assign pen_touch_irq_n_oe = irq_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic word_seen;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_seen <= 1'b0;
    end else if (start_det) begin
      word_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_start_low;
    start_det && irq_oe;
  endsequence
  sequence s_rearm;
    conv_done && arm_pending;
  endsequence

  AST_DEFAULTS: assert property (!word_seen |-> pen_en && power_bit_upper && !power_bit_lower) // [R4] [R20]
    else $error("power-up defaults wrong");
  AST_START_MASKS: assert property (start_det |=> !pen_en && !arm_pending) // [R5] [R10]
    else $error("start flag did not mask pen interrupt");
  AST_HOLD_LOW: assert property (s_start_low |=> irq_oe && hold) // [R6]
    else $error("interrupt not held low after start");
  AST_RELEASE_FOURTH: assert property (release_now |=> !irq_oe && !pen_en) // [R6] [R7]
    else $error("release after fourth fall wrong");
  AST_REARM: assert property (s_rearm |=> pen_en) // [R9]
    else $error("pen interrupt not re-armed");
  AST_IDLE: assert property (!pen_en && !hold && !irq_oe |=> !irq_oe) // [R8]
    else $error("interrupt driven while disabled");
  AST_TOUCH: assert property (pen_en && touch_s && !start_det |=> irq_oe) // [R1] [R2]
    else $error("touch not signalled");
  AST_IGNORE: assert property (sclk_rise && bit_cnt == 4'h0 && !cmd_s |=> bit_cnt == 4'h0) // [R11]
    else $error("bits taken before start flag");
  AST_FIELDS: assert property (word_done |=> res_8bit == $past(shift[2])
    && ref_mode_select == $past(shift[1]) && power_bit_lower == $past(cmd_s)) // [R13] [R14] [R18]
    else $error("control word fields misplaced");
  AST_PWR_BOTH: assert property (word_done && shift[0] && cmd_s |=> !arm_pending) // [R19]
    else $error("both power bits did not disarm");
  AST_NEXT_WORD: assert property (word_done |=> bit_cnt == 4'h0 && conv_start) // [R17] [R3]
    else $error("shifter not ready for next word");
endmodule

// *** verification/host_serial_model.sv ***
`timescale 1ns/1ns
module host_serial_model (
  // Clock
  input wire logic ref_clk,
  // Serial command pins
  output logic serial_shift_clock,
  output logic serial_cmd_in
);
  initial begin
    serial_shift_clock = 1'b0;
    serial_cmd_in = 1'b0;
  end
  // One shift cycle, 160 ns
  task automatic shift_bit(input logic b);
    @(posedge ref_clk) #1 serial_cmd_in = b;
    repeat (9) @(posedge ref_clk);
    #1 serial_shift_clock = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 serial_shift_clock = 1'b0;
  endtask
  // Lead zeros, word MSB first, then read-out clocks
  task automatic send_word(input logic [7:0] word, input int lead, input int extra);
    repeat (lead) shift_bit(1'b0);
    for (int i = 7; i >= 0; i--) shift_bit(word[i]);
    repeat (extra) shift_bit(1'b0);
    @(posedge ref_clk) #1 serial_cmd_in = ~serial_cmd_in;
  endtask
endmodule

// *** verification/touch_adc_pen_irq_control_tb_top.sv ***
`timescale 1ns/1ns
module touch_adc_pen_irq_control_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic touch_detect = 1'b0;
  logic sck, cmd, irq_out, irq_oe, c_hi, c_mid, c_lo, res8, refm, refp, pu, pl, cst, busy;
  int miscompares = 0;
  int checked = 0;
  int pulses = 0;
  wire logic [7:0] fields = {c_hi, c_mid, c_lo, res8, refm, refp, pu, pl};
  wire logic pen_pin = irq_oe ? irq_out : 1'b1;
  wire logic [7:0] status = {5'h00, pen_pin, irq_oe, busy};
  always #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (cst === 1'b1) pulses++;
  touch_adc_pen_irq_control u_touch_adc_pen_irq_control (
    .ref_clk(ref_clk), .rst(rst), .serial_shift_clock(sck), .serial_cmd_in(cmd),
    .touch_detect(touch_detect), .pen_touch_irq_n_out(irq_out), .pen_touch_irq_n_oe(irq_oe),
    .chan_sel_hi(c_hi), .chan_sel_mid(c_mid), .chan_sel_lo(c_lo), .res_8bit(res8),
    .ref_mode_select(refm), .ref_from_pin(refp), .power_bit_upper(pu),
    .power_bit_lower(pl), .conv_start(cst), .conv_busy(busy)
  );
  host_serial_model u_host_serial_model (
    .ref_clk(ref_clk), .serial_shift_clock(sck), .serial_cmd_in(cmd)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic falls(input int n);
    repeat (n) @(negedge sck);
  endtask
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog, about ten times the expected run
  initial begin
    wt(20000);
    miscompares++;
    end_of_test();
  end
  initial begin
    wt(2);
    #1 rst = 1'b0;
    chk("reset fields", 8'h0e, fields);
    chk("reset status", 8'h04, status);
    $display("test reset done");
    touch_detect = 1'b1;
    wt(6);
    chk("touch status", 8'h02, status);
    fork
      u_host_serial_model.send_word(8'hd0, 0, 12);
      begin
        falls(3);
        wt(5);
        chk("hold status", 8'h02, status);
        falls(1);
        wt(6);
        chk("release status", 8'h04, status);
        falls(5);
        wt(6);
        chk("convert status", 8'h05, status);
      end
    join
    wt(6);
    chk("word fields", 8'ha0, fields);
    chk("rearm status", 8'h02, status);
    $display("test start and release done");
    u_host_serial_model.send_word(8'haf, 0, 7);
    wt(6);
    chk("8bit fields", 8'h5f, fields);
    chk("8bit status", 8'h04, status);
    $display("test 8-bit always-on done");
    u_host_serial_model.send_word(8'hf6, 3, 11);
    wt(6);
    chk("lead fields", 8'hee, fields);
    chk("lead status", 8'h02, status);
    chk("pulses", 8'h03, 8'(pulses));
    $display("test leading zeros done");
    u_host_serial_model.send_word(8'ha8, 0, 2);
    chk("overlap status", 8'h05, status);
    fork
      u_host_serial_model.send_word(8'hb3, 0, 11);
      begin
        falls(5);
        wt(6);
        chk("overlap masked", 8'h04, status);
      end
    join
    wt(6);
    chk("overlap fields", 8'h63, fields);
    chk("overlap end", 8'h04, status);
    chk("overlap pulses", 8'h05, 8'(pulses));
    $display("test overlap done");
    #1 touch_detect = 1'b0;
    wt(6);
    chk("idle status", 8'h04, status);
    $display("test idle done");
    end_of_test();
  end
endmodule
